// ==== cgp_copro.sv ====
// coprocessor end: interface register slave for the general handshake
// assumes the processor end on the same clk; user logic posts responses
`timescale 1ns/10ps
`default_nettype none
module cgp_copro (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  my_id,
    input  wire logic        rsp_load,
    input  wire logic [15:0] rsp_word,
    output logic             cmd_valid,
    output logic [15:0]      cmd_out,
    output logic             rsp_taken,
    cgp_if.copro             bus
);
    logic        sel_ff, nxt_sel;
    logic        ack_ff, nxt_ack;
    logic [15:0] rd_ff, nxt_rd;
    logic [15:0] rsp_ff, nxt_rsp;
    logic [15:0] cmd_ff, nxt_cmd;
    logic        cv_ff, nxt_cv, rt_ff, nxt_rt;
    logic        hit;

    // chip select from function code, cycle type and identifier
    assign hit = !bus.as_n && bus.fc == cgp_pkg::FC_CPU_SPACE
              && bus.addr[cgp_pkg::CYC_HI:cgp_pkg::CYC_LO] == cgp_pkg::CYC_COPROC
              && bus.addr[cgp_pkg::ID_HI:cgp_pkg::ID_LO] == my_id;

    always_comb begin
        nxt_sel = sel_ff;
        nxt_ack = ack_ff;
        nxt_rd  = rd_ff;
        nxt_rsp = rsp_ff;
        nxt_cmd = cmd_ff;
        nxt_cv  = 1'b0;
        nxt_rt  = 1'b0;
        if (rsp_load)
            nxt_rsp = rsp_word;
        if (hit && !sel_ff) begin
            nxt_sel = 1'b1;
            nxt_ack = 1'b1;
            if (!bus.rw && bus.addr[4:0] == cgp_pkg::REG_COMMAND) begin
                nxt_cmd = bus.wdata;
                nxt_cv  = 1'b1;
            end else if (bus.rw && bus.addr[4:0] == cgp_pkg::REG_RESPONSE) begin
                nxt_rd = rsp_ff;
                nxt_rt = 1'b1;
            end else begin
                nxt_rd = 16'h0000;
            end
        end else if (bus.as_n) begin
            nxt_sel = 1'b0;
            nxt_ack = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sel_ff <= 1'b0;
            ack_ff <= 1'b0;
            rd_ff  <= 16'h0000;
            rsp_ff <= cgp_pkg::RSP_RESET;
            cmd_ff <= 16'h0000;
            cv_ff  <= 1'b0;
            rt_ff  <= 1'b0;
        end else begin
            sel_ff <= nxt_sel;
            ack_ff <= nxt_ack;
            rd_ff  <= nxt_rd;
            rsp_ff <= nxt_rsp;
            cmd_ff <= nxt_cmd;
            cv_ff  <= nxt_cv;
            rt_ff  <= nxt_rt;
        end
    end

    assign bus.dsack_n = ~ack_ff;
    assign bus.rdata   = rd_ff;
    assign cmd_valid   = cv_ff;
    assign cmd_out     = cmd_ff;
    assign rsp_taken   = rt_ff;
endmodule
`default_nettype wire

// ==== cgp_if.sv ====
// interface joining processor end and coprocessor end
// assumes both ends run on the same clk; one word bus cycle at a time
`timescale 1ns/10ps
`default_nettype none
interface cgp_if;
    logic [2:0]  fc;
    logic [31:0] addr;
    logic        as_n;
    logic        rw;
    logic [15:0] wdata;
    logic [15:0] rdata;
    logic        dsack_n;
    modport proc (output fc, output addr, output as_n, output rw, output wdata,
                  input rdata, input dsack_n);
    modport copro (input fc, input addr, input as_n, input rw, input wdata,
                   output rdata, output dsack_n);
endinterface
`default_nettype wire

// ==== cgp_pkg.sv ====
// package for the general coprocessor instruction handshake
// assumes a single clock shared by processor end and coprocessor end
package cgp_pkg;
    localparam logic [3:0]  OPCLASS_LINE      = 4'hF;
    localparam int          OPCLASS_HI        = 15;
    localparam int          OPCLASS_LO        = 12;
    localparam int          COPROCESSOR_IDENTIFIER_HI           = 11;
    localparam int          COPROCESSOR_IDENTIFIER_LO           = 9;
    localparam int          CAT_HI            = 8;
    localparam int          CAT_LO            = 6;
    localparam logic [2:0]  CAT_GENERAL       = 3'h0;
    localparam int          EA_HI             = 5;
    localparam int          EA_LO             = 0;
    localparam logic [2:0]  FC_CPU_SPACE      = 3'h7;
    localparam logic [3:0]  CYC_COPROC        = 4'h2;
    localparam int          CYC_HI            = 19;
    localparam int          CYC_LO            = 16;
    localparam int          ID_HI             = 15;
    localparam int          ID_LO             = 13;
    localparam logic [4:0]  REG_RESPONSE      = 5'h00;
    localparam logic [4:0]  REG_COMMAND       = 5'h0A;
    localparam logic [4:0]  REG_OPERAND       = 5'h10;
    // response word layout: bit15 releases, bit14 repeat request,
    // bit13 asks for an address calculation, bit12 processing finished
    localparam int          RSP_RELEASE       = 15;
    localparam int          RSP_REPEAT        = 14;
    localparam int          RSP_EA_REQ        = 13;
    localparam int          RSP_DONE          = 12;
    localparam logic [15:0] RSP_RESET         = 16'h0000;
    localparam logic [3:0]  SVC_CYCLES        = 4'h3;
    typedef enum logic [2:0] {
        CGP_IDLE   = 3'b000,
        CGP_CMD    = 3'b001,
        CGP_RSP    = 3'b011,
        CGP_SVC    = 3'b010,
        CGP_REL    = 3'b110,
        CGP_BAD    = 3'b111
    } cgp_state_t;
endpackage

// ==== cgp_proc.sv ====
// processor end: runs a general coprocessor instruction over the bus
// assumes a coprocessor that terminates every cycle with dsack_n
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module cgp_proc (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] op_word,
    input  wire logic [15:0] cmd_word,
    input  wire logic [15:0] ext_word,
    input  wire logic [31:0] scan_ptr,
    input  wire logic        trace_pending,
    output logic             busy,
    output logic             illegal,
    output logic             release_pulse,
    output logic [31:0]      next_fetch,
    output logic [5:0]       ea_spec,
    output logic [15:0]      ea_ext,
    output logic             ea_strobe,
    cgp_if.proc              bus
);
    cgp_pkg::cgp_state_t state_ff, nxt_state;
    logic [15:0] op_ff, nxt_op;
    logic [15:0] cmd_ff, nxt_cmd;
    logic [15:0] ext_ff, nxt_ext;
    logic [15:0] rsp_ff, nxt_rsp;
    logic [3:0]  svc_ff, nxt_svc;
    logic        cyc_ff, nxt_cyc;
    logic        ack_s1_ff, ack_s2_ff;
    logic [15:0] rd_s1_ff, rd_s2_ff;
    logic        busy_ff, nxt_busy, ill_ff, nxt_ill, rel_ff, nxt_rel;
    logic [31:0] nf_ff, nxt_nf;
    logic [5:0]  eas_ff, nxt_eas;
    logic [15:0] eax_ff, nxt_eax;
    logic        eas_stb_ff, nxt_eas_stb;
    logic [2:0]  fc_ff, nxt_fc;
    logic [31:0] addr_ff, nxt_addr;
    logic        as_ff, nxt_as;
    logic        rw_ff, nxt_rw;
    logic [15:0] wd_ff, nxt_wd;

    function automatic logic [31:0] cir_addr(input logic [2:0] id, input logic [4:0] sel);
        cir_addr = '0;
        cir_addr[cgp_pkg::CYC_HI:cgp_pkg::CYC_LO] = cgp_pkg::CYC_COPROC;
        cir_addr[cgp_pkg::ID_HI:cgp_pkg::ID_LO] = id;
        cir_addr[4:0] = sel;
    endfunction

    function automatic logic is_general(input logic [15:0] w);
        is_general = (w[cgp_pkg::OPCLASS_HI:cgp_pkg::OPCLASS_LO] == cgp_pkg::OPCLASS_LINE)
                  && (w[cgp_pkg::CAT_HI:cgp_pkg::CAT_LO] == cgp_pkg::CAT_GENERAL);
    endfunction

    // dsack and read data come from another device: two flops first
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_ff <= 1'b0;
            ack_s2_ff <= 1'b0;
            rd_s1_ff  <= 16'h0000;
            rd_s2_ff  <= 16'h0000;
        end else begin
            ack_s1_ff <= ~bus.dsack_n;
            ack_s2_ff <= ack_s1_ff;
            rd_s1_ff  <= bus.rdata;
            rd_s2_ff  <= rd_s1_ff;
        end
    end

    always_comb begin
        nxt_state   = state_ff;
        nxt_op      = op_ff;
        nxt_cmd     = cmd_ff;
        nxt_ext     = ext_ff;
        nxt_rsp     = rsp_ff;
        nxt_svc     = svc_ff;
        nxt_cyc     = cyc_ff;
        nxt_busy    = busy_ff;
        nxt_ill     = 1'b0;
        nxt_rel     = 1'b0;
        nxt_nf      = nf_ff;
        nxt_eas     = eas_ff;
        nxt_eax     = eax_ff;
        nxt_eas_stb = 1'b0;
        nxt_fc      = fc_ff;
        nxt_addr    = addr_ff;
        nxt_as      = as_ff;
        nxt_rw      = rw_ff;
        nxt_wd      = wd_ff;
        unique case (state_ff)
            cgp_pkg::CGP_IDLE: begin
                if (instr_valid) begin
                    if (is_general(op_word)) begin
                        nxt_op    = op_word;
                        nxt_cmd   = cmd_word;
                        nxt_ext   = ext_word;
                        nxt_busy  = 1'b1;
                        nxt_state = cgp_pkg::CGP_CMD;
                    end else begin
                        nxt_ill = 1'b1;
                    end
                end
            end
            cgp_pkg::CGP_CMD: begin
                if (!cyc_ff) begin
                    nxt_cyc  = 1'b1;
                    nxt_fc   = cgp_pkg::FC_CPU_SPACE;
                    nxt_addr = cir_addr(op_ff[cgp_pkg::COPROCESSOR_IDENTIFIER_HI:cgp_pkg::COPROCESSOR_IDENTIFIER_LO],
                                        cgp_pkg::REG_COMMAND);
                    nxt_rw   = 1'b0;
                    nxt_wd   = cmd_ff;
                    nxt_as   = 1'b1;
                end else if (as_ff && ack_s2_ff) begin
                    nxt_as = 1'b0;
                end else if (!as_ff && !ack_s2_ff) begin
                    nxt_cyc   = 1'b0;
                    nxt_state = cgp_pkg::CGP_RSP;
                end
            end
            cgp_pkg::CGP_RSP: begin
                if (!cyc_ff) begin
                    nxt_cyc  = 1'b1;
                    nxt_fc   = cgp_pkg::FC_CPU_SPACE;
                    nxt_addr = cir_addr(op_ff[cgp_pkg::COPROCESSOR_IDENTIFIER_HI:cgp_pkg::COPROCESSOR_IDENTIFIER_LO],
                                        cgp_pkg::REG_RESPONSE);
                    nxt_rw   = 1'b1;
                    nxt_as   = 1'b1;
                end else if (as_ff && ack_s2_ff) begin
                    nxt_rsp = rd_s2_ff;
                    nxt_as  = 1'b0;
                end else if (!as_ff && !ack_s2_ff) begin
                    nxt_cyc = 1'b0;
                    nxt_svc = cgp_pkg::SVC_CYCLES;
                    if (rsp_ff[cgp_pkg::RSP_EA_REQ]) begin
                        nxt_eas     = op_ff[cgp_pkg::EA_HI:cgp_pkg::EA_LO];
                        nxt_eax     = ext_ff;
                        nxt_eas_stb = 1'b1;
                    end
                    if (rsp_ff[cgp_pkg::RSP_REPEAT] || rsp_ff[cgp_pkg::RSP_EA_REQ])
                        nxt_state = cgp_pkg::CGP_SVC;
                    else if (rsp_ff[cgp_pkg::RSP_RELEASE]
                             && (!trace_pending || rsp_ff[cgp_pkg::RSP_DONE]))
                        nxt_state = cgp_pkg::CGP_REL;
                    else
                        nxt_state = cgp_pkg::CGP_SVC;
                end
            end
            cgp_pkg::CGP_SVC: begin
                // fixed service time stands in for the processor's own work
                nxt_svc = svc_ff - 4'h1;
                if (svc_ff == 4'h0)
                    nxt_state = cgp_pkg::CGP_RSP;
            end
            cgp_pkg::CGP_REL: begin
                nxt_nf    = scan_ptr;
                nxt_rel   = 1'b1;
                nxt_busy  = 1'b0;
                nxt_fc    = 3'h0;
                nxt_addr  = '0;
                nxt_state = cgp_pkg::CGP_IDLE;
            end
            default: nxt_state = cgp_pkg::CGP_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff   <= cgp_pkg::CGP_IDLE;
            op_ff      <= 16'h0000;
            cmd_ff     <= 16'h0000;
            ext_ff     <= 16'h0000;
            rsp_ff     <= cgp_pkg::RSP_RESET;
            svc_ff     <= 4'h0;
            cyc_ff     <= 1'b0;
            busy_ff    <= 1'b0;
            ill_ff     <= 1'b0;
            rel_ff     <= 1'b0;
            nf_ff      <= 32'h0000_0000;
            eas_ff     <= 6'h00;
            eax_ff     <= 16'h0000;
            eas_stb_ff <= 1'b0;
            fc_ff      <= 3'h0;
            addr_ff    <= 32'h0000_0000;
            as_ff      <= 1'b0;
            rw_ff      <= 1'b1;
            wd_ff      <= 16'h0000;
        end else begin
            state_ff   <= nxt_state;
            op_ff      <= nxt_op;
            cmd_ff     <= nxt_cmd;
            ext_ff     <= nxt_ext;
            rsp_ff     <= nxt_rsp;
            svc_ff     <= nxt_svc;
            cyc_ff     <= nxt_cyc;
            busy_ff    <= nxt_busy;
            ill_ff     <= nxt_ill;
            rel_ff     <= nxt_rel;
            nf_ff      <= nxt_nf;
            eas_ff     <= nxt_eas;
            eax_ff     <= nxt_eax;
            eas_stb_ff <= nxt_eas_stb;
            fc_ff      <= nxt_fc;
            addr_ff    <= nxt_addr;
            as_ff      <= nxt_as;
            rw_ff      <= nxt_rw;
            wd_ff      <= nxt_wd;
        end
    end

    assign busy          = busy_ff;
    assign illegal       = ill_ff;
    assign release_pulse = rel_ff;
    assign next_fetch    = nf_ff;
    assign ea_spec       = eas_ff;
    assign ea_ext        = eax_ff;
    assign ea_strobe     = eas_stb_ff;
    assign bus.fc        = fc_ff;
    assign bus.addr      = addr_ff;
    assign bus.as_n      = ~as_ff;
    assign bus.rw        = rw_ff;
    assign bus.wdata     = wd_ff;
endmodule
`default_nettype wire

// ==== cgp_props.sv ====
// checker for the bus joining processor end and coprocessor end
// assumes placement beside cgp_if, with COPROCESSOR_IDENTIFIER equal to the coprocessor's id
`timescale 1ns/10ps
`default_nettype none
module cgp_props #(
    parameter logic [2:0] COPROCESSOR_IDENTIFIER = 3'h0
) (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  fc,
    input  wire logic [31:0] addr,
    input  wire logic        as_n,
    input  wire logic        rw,
    input  wire logic [15:0] wdata,
    input  wire logic [15:0] rdata,
    input  wire logic        dsack_n
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    AST_FC_CPU: assert property (!as_n |-> fc == cgp_pkg::FC_CPU_SPACE)
        else $error("function code not cpu space");
    AST_CYC_TYPE: assert property (!as_n |-> addr[19:16] == cgp_pkg::CYC_COPROC)
        else $error("cycle type wrong");
    AST_COPROCESSOR_IDENTIFIER: assert property (!as_n |-> addr[15:13] == COPROCESSOR_IDENTIFIER)
        else $error("identifier wrong on address");
    AST_ZERO_BITS: assert property (!as_n |-> addr[31:20] == 12'h000 && addr[12:5] == 8'h00)
        else $error("unused address bits not zero");
    AST_WR_CMD: assert property ($fell(as_n) && !rw |-> addr[4:0] == cgp_pkg::REG_COMMAND)
        else $error("write not to command register");
    AST_RD_RSP: assert property ($fell(as_n) && rw |-> addr[4:0] == cgp_pkg::REG_RESPONSE)
        else $error("read not from response register");
    AST_HOLD: assert property (!as_n && !$fell(as_n) |-> $stable(addr) && $stable(rw) && $stable(wdata))
        else $error("request changed while strobed");
    AST_ACK: assert property ($fell(as_n) |=> !dsack_n)
        else $error("no acknowledge one cycle after strobe");
    AST_DROP: assert property ($fell(as_n) |-> ##[2:8] as_n)
        else $error("strobe not released");
    AST_ACK_REL: assert property ($rose(as_n) |-> ##[0:2] dsack_n)
        else $error("acknowledge not released");
    cover property ($fell(as_n) && !rw);
    cover property ($fell(as_n) && rw);
    cover property ($fell(dsack_n) && rw && rdata[15]);
endmodule
`default_nettype wire

// ==== cgp_test.sv ====
// self-checking bench for both ends of the general coprocessor handshake
// assumes cgp_proc and cgp_copro facing each other through cgp_if
`timescale 1ns/10ps
`default_nettype none
module coproc_general_instr_protocol_test;
    localparam logic [2:0] ID = 3'h5;
    logic        clk, reset_n, instr_valid, trace_pending, rsp_load;
    logic [15:0] op_word, cmd_word, ext_word, rsp_word;
    logic [31:0] scan_ptr;
    logic        busy, illegal, release_pulse, ea_strobe, cmd_valid, rsp_taken;
    logic [31:0] next_fetch;
    logic [5:0]  ea_spec;
    logic [15:0] ea_ext, cmd_out, got_cmd;
    int          errors, total_checks, n_cmd, n_rsp, n_ea, n_ill, cmd_first;
    cgp_if bus_if ();
    cgp_proc cgp_proc_inst (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
        .op_word(op_word), .cmd_word(cmd_word), .ext_word(ext_word), .scan_ptr(scan_ptr),
        .trace_pending(trace_pending), .busy(busy), .illegal(illegal),
        .release_pulse(release_pulse), .next_fetch(next_fetch), .ea_spec(ea_spec),
        .ea_ext(ea_ext), .ea_strobe(ea_strobe), .bus(bus_if.proc));
    cgp_copro cgp_copro_inst (.clk(clk), .reset_n(reset_n), .my_id(ID), .rsp_load(rsp_load),
        .rsp_word(rsp_word), .cmd_valid(cmd_valid), .cmd_out(cmd_out),
        .rsp_taken(rsp_taken), .bus(bus_if.copro));
    cgp_props #(.COPROCESSOR_IDENTIFIER(ID)) cgp_props_inst (.clk(clk), .reset_n(reset_n), .fc(bus_if.fc),
        .addr(bus_if.addr), .as_n(bus_if.as_n), .rw(bus_if.rw), .wdata(bus_if.wdata),
        .rdata(bus_if.rdata), .dsack_n(bus_if.dsack_n));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    task automatic summarize();
        if (errors == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // r1 is posted after the first read and r2 after every later read, so the first three reads see r0, r1, r2
    task automatic run(input logic [15:0] op, input logic [15:0] cmd, input logic [31:0] ptr,
                       input logic tr, input logic [15:0] r0, input logic [15:0] r1,
                       input logic [15:0] r2);
        int n;
        n_cmd = 0;
        n_rsp = 0;
        n_ea = 0;
        n_ill = 0;
        cmd_first = 0;
        @(posedge clk);
        rsp_load <= 1'b1;
        rsp_word <= r0;
        op_word <= op;
        cmd_word <= cmd;
        scan_ptr <= ptr;
        trace_pending <= tr;
        @(posedge clk);
        rsp_load <= 1'b0;
        instr_valid <= 1'b1;
        @(posedge clk);
        instr_valid <= 1'b0;
        for (n = 0; n < 400; n++) begin
            @(posedge clk);
            if (illegal === 1'b1) n_ill++;
            if (cmd_valid === 1'b1) begin
                n_cmd++;
                got_cmd = cmd_out;
            end
            if (ea_strobe === 1'b1) n_ea++;
            // one assignment per edge: the load pulse follows each response read
            rsp_load <= (rsp_taken === 1'b1);
            if (rsp_taken === 1'b1) begin
                if (n_rsp == 0) cmd_first = n_cmd;
                rsp_word <= (n_rsp == 0) ? r1 : r2;
                n_rsp++;
            end
            if (release_pulse === 1'b1 || (n > 20 && busy === 1'b0)) break;
        end
        if (n == 400) begin
            errors++;
            summarize();
        end
        @(posedge clk);
        @(posedge clk);
    endtask
    task automatic t_release();
        run(16'hFA3F, 16'hC35A, 32'h0000_1234, 1'b0, 16'h8000, 16'h8000, 16'h8000);
        chk("cmd_out", got_cmd, 16'hC35A);
        chk("cmd_count", n_cmd, 1);
        chk("cmd_before_rsp", cmd_first, 1);
        chk("rsp_reads", n_rsp, 1);
        chk("ea_none", n_ea, 0);
        chk("next_fetch", next_fetch, 32'h0000_1234);
        chk("busy_after", busy, 1'b0);
    endtask
    task automatic t_repeat_ea();
        run(16'hFA15, 16'h0001, 32'h0000_2000, 1'b0, 16'h6000, 16'h8000, 16'h8000);
        chk("rsp_reads", n_rsp, 2);
        chk("ea_seen", n_ea, 1);
        chk("ea_spec", ea_spec, 6'h15);
        chk("ea_ext", ea_ext, 16'hBEEF);
        chk("next_fetch", next_fetch, 32'h0000_2000);
    endtask
    task automatic t_trace();
        run(16'hFA00, 16'h0002, 32'h0000_3000, 1'b1, 16'h8000, 16'h8000, 16'h9000);
        chk("rsp_reads", n_rsp, 3);
        chk("next_fetch", next_fetch, 32'h0000_3000);
        trace_pending <= 1'b0;
    endtask
    task automatic t_illegal();
        logic [15:0] bad [4] = '{16'hEA00, 16'hFA40, 16'hFBC0, 16'h0A00};
        foreach (bad[i]) begin
            run(bad[i], 16'h0003, 32'h0, 1'b0, 16'h8000, 16'h8000, 16'h8000);
            chk("illegal", n_ill, 1);
            chk("no_cmd", n_cmd, 0);
        end
    endtask
    initial begin
        errors = 0;
        total_checks = 0;
        reset_n = 1'b0;
        instr_valid = 1'b0;
        trace_pending = 1'b0;
        rsp_load = 1'b0;
        op_word = 16'h0000;
        cmd_word = 16'h0000;
        ext_word = 16'hBEEF;
        rsp_word = 16'h0000;
        scan_ptr = 32'h0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        t_release();
        t_repeat_ea();
        t_trace();
        t_illegal();
        summarize();
    end
endmodule
`default_nettype wire
